// ### isp_pkg.sv
// package for the input synchronisation parameter bank: register indices,
// reset values, trigger mode codes and the supported-mode bitmap
// assumes a register port with word addresses equal to the entry sub-index
package isp_pkg;

    // ------------------------------------------------------------------
    // register indices (word addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] ISP_ADDR_COUNT = 8'h00;
    localparam logic [7:0] ISP_ADDR_MODE = 8'h01;
    localparam logic [7:0] ISP_ADDR_CYCLE = 8'h02;
    localparam logic [7:0] ISP_ADDR_SHIFT = 8'h03;
    localparam logic [7:0] ISP_ADDR_SUPPORT = 8'h04;
    localparam logic [7:0] ISP_ADDR_MINCYC = 8'h05;
    localparam logic [7:0] ISP_ADDR_CALC = 8'h06;
    localparam logic [7:0] ISP_ADDR_MINDLY = 8'h07;
    localparam logic [7:0] ISP_ADDR_CMD = 8'h08;
    localparam logic [7:0] ISP_ADDR_MAXDLY = 8'h09;
    localparam logic [7:0] ISP_ADDR_MISSED = 8'h0b;
    localparam logic [7:0] ISP_ADDR_OVERRUN = 8'h0c;
    localparam logic [7:0] ISP_ADDR_SHORT = 8'h0d;
    localparam logic [7:0] ISP_ADDR_SYNCERR = 8'h20;

    // ------------------------------------------------------------------
    // reset and constant values
    // ------------------------------------------------------------------
    localparam logic [7:0] ISP_ENTRY_COUNT = 8'h20;
    localparam logic [15:0] ISP_MODE_RESET = 16'h0022;
    localparam logic [31:0] ISP_CYCLE_RESET = 32'h000f4240;
    localparam logic [15:0] ISP_SUPPORT_MAP = 16'hc007;
    localparam logic [31:0] ISP_MIN_CYCLE = 32'h0000fde8;
    localparam logic [31:0] ISP_MIN_DELAY = 32'h00000000;
    localparam logic [15:0] ISP_CMD_RESET = 16'h0000;
    localparam logic [15:0] ISP_CMD_START = 16'h0001;
    localparam logic [15:0] ISP_CMD_STOP = 16'h0000;
    localparam logic [15:0] ISP_CNT_MAX = 16'hffff;

    // nanoseconds added per clock at 125 MHz
    localparam int ISP_CLK_PERIOD_NS = 8;
    localparam logic [31:0] ISP_NS_PER_CLK = 32'(ISP_CLK_PERIOD_NS);

    // ------------------------------------------------------------------
    // trigger mode codes
    // ------------------------------------------------------------------
    localparam logic [15:0] ISP_MODE_LOCAL = 16'h0000;
    localparam logic [15:0] ISP_MODE_INBUF = 16'h0001;
    localparam logic [15:0] ISP_MODE_FIRST = 16'h0002;
    localparam logic [15:0] ISP_MODE_SECOND = 16'h0003;
    localparam logic [15:0] ISP_MODE_OUTBUF = 16'h0022;

endpackage

// ### isp_input_sync_parameters.sv
// input synchronisation parameter bank with timing measurement and
// diagnostic counters for a fieldbus sensor terminal
// assumes sync pulses and buffer events arrive asynchronously on pins;
// sampleDone and cycleLate come from logic on the same clock
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/1ps

// What this block does
// - trigger select encodes 0,1,2,3,34; resets 34
// - cycle period in ns, reset one million
// - shift time: first pulse to sampling
// - supported-mode map reads 0xc007
// - minimum cycle period reads 65000 ns
// - calc-and-copy: sampling to data ready
// - command write 1 starts, 0 stops measuring
// - keep maxima while measuring in modes 2 and 3, clear on start
// - max delay: second pulse to sampling
// - count missed buffer events in state_a in modes 2 and 3
// - count overrun cycles in state_a
// - count too-short pulse spacing in modes 2 and 3
// - late-output flag set in modes 2 and 3, clear at the next first pulse or outside those modes
module isp_input_sync_parameters
    import isp_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regReadData,
    // asynchronous event pins
    input wire logic firstSyncPulse,
    input wire logic secondSyncPulse,
    input wire logic inputBufferEvent,
    input wire logic outputBufferEvent,
    // same-clock status from acquisition logic
    input wire logic stateA,
    input wire logic sampleDone,
    input wire logic dataReady,
    input wire logic cycleLate,
    input wire logic outputsLate,
    // status outputs
    output logic measuring,
    output logic [15:0] triggerMode
);

    // ------------------------------------------------------------------
    // pin synchronisers and edge detect
    // ------------------------------------------------------------------
    logic [3:0] pinMeta;
    logic [3:0] pinSync;
    logic [3:0] pinLast;
    logic [3:0] pinRise;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pinMeta <= 4'h0;
            pinSync <= 4'h0;
            pinLast <= 4'h0;
        end else begin
            pinMeta <= {outputBufferEvent, inputBufferEvent, secondSyncPulse, firstSyncPulse};
            pinSync <= pinMeta;
            pinLast <= pinSync;
        end
    end

    assign pinRise = pinSync & ~pinLast;

    logic firstEdge;
    logic secondEdge;
    logic inBufEdge;
    logic outBufEdge;
    assign firstEdge = pinRise[0];
    assign secondEdge = pinRise[1];
    assign inBufEdge = pinRise[2];
    assign outBufEdge = pinRise[3];

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    logic [15:0] modeSel;
    logic [31:0] cyclePeriod;
    logic [15:0] measureCmd;
    logic clockMode;

    // mode 3 still starts its cycle on the first pulse
    assign clockMode = (modeSel == ISP_MODE_FIRST) || (modeSel == ISP_MODE_SECOND);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            modeSel <= ISP_MODE_RESET;
            cyclePeriod <= ISP_CYCLE_RESET;
            measureCmd <= ISP_CMD_RESET;
        end else if (regWrite) begin
            unique case (regAddr)
                ISP_ADDR_MODE: begin
                    // unknown codes are refused so the trigger stays defined
                    if (regWriteData[15:0] == ISP_MODE_LOCAL
                        || regWriteData[15:0] == ISP_MODE_INBUF
                        || regWriteData[15:0] == ISP_MODE_FIRST
                        || regWriteData[15:0] == ISP_MODE_SECOND
                        || regWriteData[15:0] == ISP_MODE_OUTBUF) begin
                        modeSel <= regWriteData[15:0];
                    end
                end
                ISP_ADDR_CYCLE: cyclePeriod <= regWriteData;
                ISP_ADDR_CMD: measureCmd <= regWriteData[15:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // measurement control
    // ------------------------------------------------------------------
    logic startPulse;
    assign startPulse = regWrite && (regAddr == ISP_ADDR_CMD)
        && (regWriteData[15:0] == ISP_CMD_START);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            measuring <= 1'b0;
        end else if (regWrite && regAddr == ISP_ADDR_CMD) begin
            if (regWriteData[15:0] == ISP_CMD_START) begin
                measuring <= 1'b1;
            end else if (regWriteData[15:0] == ISP_CMD_STOP) begin
                measuring <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            triggerMode <= ISP_MODE_RESET;
        end else begin
            triggerMode <= modeSel;
        end
    end

    // ------------------------------------------------------------------
    // elapsed-time counters in nanoseconds
    // ------------------------------------------------------------------
    // the pulse counters run from their pulse to sampling, the sample counter to data ready; saturating so a lost
    // sample cannot produce a small bogus maximum
    logic [31:0] sinceFirst;
    logic [31:0] sinceSecond;
    logic [31:0] sinceSample;
    logic run0;
    logic run1;
    logic runS;

    function automatic logic [31:0] ns_step(input logic [31:0] value);
        ns_step = (value > 32'hffffffff - ISP_NS_PER_CLK) ? 32'hffffffff : value + ISP_NS_PER_CLK;
    endfunction

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sinceFirst <= 32'h0;
            sinceSecond <= 32'h0;
            sinceSample <= 32'h0;
            run0 <= 1'b0;
            run1 <= 1'b0;
            runS <= 1'b0;
        end else begin
            // the starting clock counts, so a one-clock gap reads as 8 ns
            if (firstEdge) begin
                sinceFirst <= ISP_NS_PER_CLK;
                run0 <= 1'b1;
            end else if (sampleDone) begin
                run0 <= 1'b0;
            end else if (run0) begin
                sinceFirst <= ns_step(sinceFirst);
            end
            if (secondEdge) begin
                sinceSecond <= ISP_NS_PER_CLK;
                run1 <= 1'b1;
            end else if (sampleDone) begin
                run1 <= 1'b0;
            end else if (run1) begin
                sinceSecond <= ns_step(sinceSecond);
            end
            if (sampleDone) begin
                sinceSample <= ISP_NS_PER_CLK;
                runS <= 1'b1;
            end else if (dataReady) begin
                runS <= 1'b0;
            end else if (runS) begin
                sinceSample <= ns_step(sinceSample);
            end
        end
    end

    // ------------------------------------------------------------------
    // measured maxima
    // ------------------------------------------------------------------
    logic [31:0] shiftMax;
    logic [31:0] calcMax;
    logic [31:0] delayMax;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            shiftMax <= 32'h0;
            calcMax <= 32'h0;
            delayMax <= 32'h0;
        end else if (startPulse) begin
            shiftMax <= 32'h0;
            calcMax <= 32'h0;
            delayMax <= 32'h0;
        end else if (measuring && clockMode) begin
            if (sampleDone && run0 && sinceFirst > shiftMax) begin
                shiftMax <= sinceFirst;
            end
            if (dataReady && runS && sinceSample > calcMax) begin
                calcMax <= sinceSample;
            end
            if (sampleDone && run1 && sinceSecond > delayMax) begin
                delayMax <= sinceSecond;
            end
        end
    end

    // ------------------------------------------------------------------
    // diagnostic counters
    // ------------------------------------------------------------------
    logic [15:0] missedCount;
    logic [15:0] overrunCount;
    logic [15:0] shortCount;
    logic lateFlag;
    logic expectBuf;
    logic stateALast;
    logic leaveA;

    function automatic logic [15:0] sat_inc(input logic [15:0] value);
        sat_inc = (value == ISP_CNT_MAX) ? value : value + 16'h0001;
    endfunction

    assign leaveA = stateALast && !stateA;

    // a buffer event is expected once per first sync pulse; the next first pulse
    // with none seen since counts as a miss
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            expectBuf <= 1'b0;
            stateALast <= 1'b0;
        end else begin
            stateALast <= stateA;
            if (firstEdge) begin
                expectBuf <= 1'b1;
            end else if (inBufEdge || outBufEdge) begin
                expectBuf <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            missedCount <= 16'h0;
            overrunCount <= 16'h0;
            shortCount <= 16'h0;
        end else if (leaveA) begin
            missedCount <= 16'h0;
            overrunCount <= 16'h0;
            shortCount <= 16'h0;
        end else begin
            if (stateA && clockMode && firstEdge && expectBuf && !inBufEdge && !outBufEdge) begin
                missedCount <= sat_inc(missedCount);
            end
            if (stateA && cycleLate) begin
                overrunCount <= sat_inc(overrunCount);
            end
            // second pulse before sampling finished counts as too short
            if (clockMode && secondEdge && run0) begin
                shortCount <= sat_inc(shortCount);
            end
        end
    end

    // flag reflects the most recent cycle: set on late outputs, cleared at
    // the next cycle start; a late report in that same cycle wins
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            lateFlag <= 1'b0;
        end else if (clockMode && outputsLate) begin
            lateFlag <= 1'b1;
        end else if (firstEdge || !clockMode) begin
            lateFlag <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // read port
    // ------------------------------------------------------------------
    logic [31:0] next_readData;

    always_comb begin
        next_readData = 32'h0;
        unique case (regAddr)
            ISP_ADDR_COUNT: next_readData = {24'h0, ISP_ENTRY_COUNT};
            ISP_ADDR_MODE: next_readData = {16'h0, modeSel};
            ISP_ADDR_CYCLE: next_readData = cyclePeriod;
            ISP_ADDR_SHIFT: next_readData = shiftMax;
            ISP_ADDR_SUPPORT: next_readData = {16'h0, ISP_SUPPORT_MAP};
            ISP_ADDR_MINCYC: next_readData = ISP_MIN_CYCLE;
            ISP_ADDR_CALC: next_readData = calcMax;
            ISP_ADDR_MINDLY: next_readData = ISP_MIN_DELAY;
            ISP_ADDR_CMD: next_readData = {16'h0, measureCmd};
            ISP_ADDR_MAXDLY: next_readData = delayMax;
            ISP_ADDR_MISSED: next_readData = {16'h0, missedCount};
            ISP_ADDR_OVERRUN: next_readData = {16'h0, overrunCount};
            ISP_ADDR_SHORT: next_readData = {16'h0, shortCount};
            ISP_ADDR_SYNCERR: next_readData = {31'h0, lateFlag};
            default: next_readData = 32'h0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            regReadData <= 32'h0;
        end else if (regRead) begin
            regReadData <= next_readData;
        end else begin
            regReadData <= 32'h0;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    a_mode_default: assert property (@(posedge clk)
        $rose(reset_n) |-> modeSel == ISP_MODE_RESET)
        else $error("trigger select not at default after reset");
    a_cycle_write: assert property (@(posedge clk) disable iff (!reset_n)
        regWrite && regAddr == ISP_ADDR_CYCLE |=> cyclePeriod == $past(regWriteData))
        else $error("cycle period write lost");
    a_support_read: assert property (@(posedge clk) disable iff (!reset_n)
        regRead && regAddr == ISP_ADDR_SUPPORT |=> regReadData == 32'h0000c007)
        else $error("supported map wrong");
    a_mincyc_read: assert property (@(posedge clk) disable iff (!reset_n)
        regRead && regAddr == ISP_ADDR_MINCYC |=> regReadData == 32'd65000)
        else $error("minimum cycle wrong");
    a_cmd_start: assert property (@(posedge clk) disable iff (!reset_n)
        startPulse |=> measuring && shiftMax == 32'h0 && calcMax == 32'h0 && delayMax == 32'h0)
        else $error("start did not clear maxima");
    a_max_monotone: assert property (@(posedge clk) disable iff (!reset_n)
        !startPulse |=> shiftMax >= $past(shiftMax) && delayMax >= $past(delayMax))
        else $error("maximum decreased without restart");
    a_shift_capture: assert property (@(posedge clk) disable iff (!reset_n)
        measuring && clockMode && !startPulse && sampleDone && run0
        |=> shiftMax >= $past(sinceFirst))
        else $error("shift time not captured");
    a_calc_capture: assert property (@(posedge clk) disable iff (!reset_n)
        measuring && clockMode && !startPulse && dataReady && runS
        |=> calcMax >= $past(sinceSample))
        else $error("calc and copy time not captured");
    a_delay_capture: assert property (@(posedge clk) disable iff (!reset_n)
        measuring && clockMode && !startPulse && sampleDone && run1
        |=> delayMax >= $past(sinceSecond))
        else $error("second pulse delay not captured");
    a_missed_count: assert property (@(posedge clk) disable iff (!reset_n)
        stateA && clockMode && firstEdge && expectBuf && !inBufEdge && !outBufEdge
        && missedCount != ISP_CNT_MAX |=> missedCount == $past(missedCount) + 16'h0001)
        else $error("missed buffer event not counted");
    a_overrun_count: assert property (@(posedge clk) disable iff (!reset_n)
        stateA && stateALast && cycleLate && overrunCount != ISP_CNT_MAX
        |=> overrunCount == $past(overrunCount) + 16'h0001)
        else $error("overrun not counted");
    a_short_count: assert property (@(posedge clk) disable iff (!reset_n)
        !leaveA && clockMode && secondEdge && run0 && shortCount != ISP_CNT_MAX
        |=> shortCount == $past(shortCount) + 16'h0001)
        else $error("short pulse spacing not counted");
    a_leave_clear: assert property (@(posedge clk) disable iff (!reset_n)
        leaveA |=> missedCount == 16'h0 && overrunCount == 16'h0 && shortCount == 16'h0)
        else $error("counters not cleared leaving state_a");
    a_late_flag: assert property (@(posedge clk) disable iff (!reset_n)
        clockMode && outputsLate |=> lateFlag)
        else $error("late flag not set");

endmodule

// ### isp_event_source.sv
// far-side pulse source: sync pulses and buffer events as the master makes them
// assumes one-cycle request strobes, sampled on the rising edge of clk
`timescale 1ns/1ps

module isp_event_source (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // requests: bit 0 first sync, 1 second sync, 2 input buffer, 3 output buffer
    input wire logic [3:0] fire,
    // event pins, idle low between pulses
    output logic [3:0] pins
);
    logic [2:0] hold [4];

    // ------------------------------------------------------------------
    // pulse stretch
    // ------------------------------------------------------------------
    // four clocks high so the two-flop synchroniser cannot miss an edge
    always_ff @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            if (!reset_n) begin
                hold[i] <= 3'h0;
                pins[i] <= 1'b0;
            end else begin
                if (fire[i]) begin
                    hold[i] <= 3'h4;
                end else if (hold[i] != 3'h0) begin
                    hold[i] <= hold[i] - 3'h1;
                end
                pins[i] <= fire[i] || (hold[i] > 3'h1);
            end
        end
    end
endmodule

// ### isp_input_sync_parameters_test.sv
// self-checking bench for the input synchronisation parameter bank
// assumes the event source model drives the four event pins
`timescale 1ns/1ps

module isp_input_sync_parameters_test
    import isp_pkg::*;
;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWriteData = 32'h0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [31:0] regReadData;
    logic [3:0] fire = 4'h0;
    logic [3:0] pins;
    logic stateA = 1'b0;
    logic sampleDone = 1'b0;
    logic dataReady = 1'b0;
    logic cycleLate = 1'b0;
    logic outputsLate = 1'b0;
    logic measuring;
    logic [15:0] triggerMode;
    int fails = 0;
    int checks = 0;
    int seed = 32'h7969;
    logic [31:0] expReg [33];
    logic [7:0] roList [11] = '{8'h00, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h09,
        8'h0b, 8'h0c, 8'h0d, 8'h20};
    logic [15:0] codes [5] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0022};

    isp_event_source i_src (.clk(clk), .reset_n(reset_n), .fire(fire), .pins(pins));

    isp_input_sync_parameters i_dut (
        .clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWriteData(regWriteData),
        .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
        .firstSyncPulse(pins[0]), .secondSyncPulse(pins[1]),
        .inputBufferEvent(pins[2]), .outputBufferEvent(pins[3]),
        .stateA(stateA), .sampleDone(sampleDone), .dataReady(dataReady),
        .cycleLate(cycleLate), .outputsLate(outputsLate),
        .measuring(measuring), .triggerMode(triggerMode)
    );

    initial begin
        forever #4 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWriteData <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask

    // read data stand one cycle only, then the port must go back to zero
    task automatic readAll();
        for (int a = 0; a < 33; a++) begin
            @(posedge clk);
            regRead <= 1'b1;
            regAddr <= 8'(a);
            @(posedge clk);
            regRead <= 1'b0;
            @(negedge clk);
            check($sformatf("entry %h", a), regReadData, expReg[a]);
            @(negedge clk);
            check("idle read data", regReadData, 32'h0);
        end
    endtask

    // cycle indices of each request; -1 leaves it out
    task automatic seq(input int s1, input int s0, input int bf, input int sd, input int dr);
        for (int c = 0; c < 40; c++) begin
            @(posedge clk);
            fire <= {bf == c, bf == c, s1 == c, s0 == c};
            sampleDone <= (sd == c);
            dataReady <= (dr == c);
        end
    endtask

    // event edges act three clocks after the pin rises
    task automatic meas(input logic keep);
        int k;
        int j;
        int m;
        k = 1 + ($unsigned($random(seed)) % 4);
        j = k + 1 + ($unsigned($random(seed)) % 6);
        m = 1 + ($unsigned($random(seed)) % 8);
        seq(0, j - k, -1, j + 3, j + 3 + m);
        if (keep && 32'(k * 8) > expReg[3]) expReg[3] = 32'(k * 8);
        if (keep && 32'(m * 8) > expReg[6]) expReg[6] = 32'(m * 8);
        if (keep && 32'(j * 8) > expReg[9]) expReg[9] = 32'(j * 8);
    endtask

    task automatic pulse(input int which, input int n);
        repeat (n) begin
            @(posedge clk);
            if (which == 0) cycleLate <= 1'b1;
            else outputsLate <= 1'b1;
            @(posedge clk);
            cycleLate <= 1'b0;
            outputsLate <= 1'b0;
        end
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        for (int a = 0; a < 33; a++) expReg[a] = 32'h0;
        expReg[ISP_ADDR_COUNT] = 32'h20;
        expReg[ISP_ADDR_MODE] = 32'h22;
        expReg[ISP_ADDR_CYCLE] = 32'h000f4240;
        expReg[ISP_ADDR_SUPPORT] = 32'hc007;
        expReg[ISP_ADDR_MINCYC] = 32'h0000fde8;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        readAll();
        check("trigger mode", 32'(triggerMode), 32'h22);
        foreach (roList[i]) wr(roList[i], $random(seed));
        readAll();
        foreach (codes[i]) begin
            wr(ISP_ADDR_MODE, 32'(codes[i]));
            wr(ISP_ADDR_MODE, 32'(5 + i));
            repeat (2) @(negedge clk);
            check("trigger mode", 32'(triggerMode), 32'(codes[i]));
        end
        expReg[ISP_ADDR_MODE] = 32'h22;
        expReg[ISP_ADDR_CYCLE] = $random(seed);
        wr(ISP_ADDR_CYCLE, expReg[ISP_ADDR_CYCLE]);
        readAll();
        wr(ISP_ADDR_MODE, 32'h2);
        expReg[ISP_ADDR_MODE] = 32'h2;
        meas(1'b0);
        wr(ISP_ADDR_CMD, 32'h1);
        expReg[ISP_ADDR_CMD] = 32'h1;
        @(negedge clk);
        check("measuring", 32'(measuring), 32'h1);
        repeat (3) meas(1'b1);
        readAll();
        wr(ISP_ADDR_CMD, 32'h0);
        expReg[ISP_ADDR_CMD] = 32'h0;
        @(negedge clk);
        check("measuring", 32'(measuring), 32'h0);
        repeat (2) meas(1'b0);
        readAll();
        wr(ISP_ADDR_CMD, 32'h1);
        expReg[ISP_ADDR_CMD] = 32'h1;
        expReg[3] = 32'h0;
        expReg[6] = 32'h0;
        expReg[9] = 32'h0;
        readAll();
        wr(ISP_ADDR_MODE, 32'h3);
        expReg[ISP_ADDR_MODE] = 32'h3;
        repeat (2) meas(1'b1);
        wr(ISP_ADDR_CMD, 32'h0);
        expReg[ISP_ADDR_CMD] = 32'h0;
        readAll();
        // overrun outside the state_a state must not count
        pulse(0, 1);
        seq(-1, -1, 0, -1, -1);
        stateA <= 1'b1;
        pulse(0, 3);
        seq(-1, 0, -1, 10, -1);
        seq(-1, -1, 0, -1, -1);
        seq(-1, 0, -1, 10, -1);
        seq(-1, 0, -1, 10, -1);
        seq(-1, -1, 0, -1, -1);
        seq(2, 0, -1, 10, -1);
        pulse(1, 1);
        expReg[ISP_ADDR_MISSED] = 32'h1;
        expReg[ISP_ADDR_OVERRUN] = 32'h3;
        expReg[ISP_ADDR_SHORT] = 32'h1;
        expReg[ISP_ADDR_SYNCERR] = 32'h1;
        readAll();
        seq(-1, 5, 0, 15, -1);
        expReg[ISP_ADDR_SYNCERR] = 32'h0;
        readAll();
        @(posedge clk);
        stateA <= 1'b0;
        repeat (3) @(posedge clk);
        expReg[ISP_ADDR_MISSED] = 32'h0;
        expReg[ISP_ADDR_OVERRUN] = 32'h0;
        expReg[ISP_ADDR_SHORT] = 32'h0;
        readAll();
        wrap_up();
    end

    // a hang counts as a mismatch
    initial begin
        #400000;
        fails++;
        wrap_up();
    end
endmodule
